// ==== logic/single_wire_debug_link.sv ====
// How it works
// - one open-drain pin, low-only drive
// - half duplex, never send while receiving
// - start, eight data lsb first, stop
// - debug state stops processor fetch
// - clock and peripherals run unless stopped
// - entering debug leaves halt
// - debug state refreshes enabled watchdog
// - breakpoint instruction enters debug state
// - pin low at reset end enters debug
// - small package needs key under reset
// - writing zero to debug bit exits
// - system resets end debug state
// - pin low in stop starts reset
// - reply may start right after stop
// - first character 80h sets bit rate
// - nine low bits reset rate detector
// - errors abort, send break, re-detect
// - rates down to clock over 512
//
// Design decisions made here: the placing of the registers and the APB interface to the registers.
`timescale 1ns/10ps
module single_wire_debug_link (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic debug_wire_pin_i,
  output logic debug_wire_pin_o,
  output logic debug_wire_pin_oe_n,
  input wire logic small_package_i,
  input wire logic shared_reset_pin_i,
  output logic gpio_mode_o,
  input wire logic system_reset_i,
  input wire logic stop_mode_i,
  output logic stop_wake_reset_o,
  input wire logic breakpoint_instruction_i,
  output logic fetch_stop_o,
  output logic halt_exit_o,
  output logic clock_run_o,
  input wire logic watchdog_enable_i,
  output logic watchdog_refresh_o,
  output logic inject_valid_o,
  output logic [7:0] inject_opcode_o
);
  dbg_link_pkg::link_state_e st_q, st_d;
  logic [15:0] cnt_q, cnt_d;
  logic [2:0] bitn_q, bitn_d;
  logic [7:0] shift_q, shift_d;
  logic [7:0] rx_data_q, rx_data_d;
  logic rx_valid_q, rx_valid_d;
  logic [7:0] tx_data_q, tx_data_d;
  logic tx_pend_q, tx_pend_d;
  logic ferr_q, ferr_d, coll_q, coll_d, brk_q, brk_d;
  logic [31:0] key_q, key_d;
  logic unlocked_q, unlocked_d;
  logic shrst_q;
  logic restart_q, restart_d;
  logic debug_q, debug_d, bkpt_en_q, bkpt_en_d;
  logic sys_rst_q, pin_low_seen_q, pin_low_seen_d;
  logic halt_exit_q, wdt_q, wake_q, clk_run_q;
  logic inj_q, inj_d;
  logic [7:0] inj_op_q, inj_op_d;
  logic [31:0] rdata_q, rdata_d;
  logic drive_low;
  logic link_open, line_low, locked, line_break;
  logic [9:0] period;
  logic [15:0] per_m1, half_m1;
  logic wr, rd, hit, rx_byte, err;

  // gpio-only until unlocked, except while the shared reset is held
  assign link_open = !small_package_i || unlocked_q || !shared_reset_pin_i;
  assign line_low = link_open && !debug_wire_pin_i;

  autobaud_meter u_meter (
    .pclk(pclk),
    .presetn(presetn),
    .restart(restart_q),
    .line_low(line_low),
    .locked(locked),
    .bit_period(period),
    .line_break(line_break)
  );

  assign per_m1 = dbg_link_pkg::bit_span(period, 6'd1) - 16'h0001;
  assign half_m1 = dbg_link_pkg::bit_span({1'b0, period[9:1]}, 6'd1)
                   - 16'h0001;

  assign hit = paddr == dbg_link_pkg::OFF_CTRL ||
               paddr == dbg_link_pkg::OFF_STATUS ||
               paddr == dbg_link_pkg::OFF_TXDATA ||
               paddr == dbg_link_pkg::OFF_RXDATA ||
               paddr == dbg_link_pkg::OFF_INJECT;
  assign wr = psel && penable && pwrite && hit;
  assign rd = psel && penable && !pwrite && hit;
  assign pready = 1'b1;
  assign pslverr = psel && penable && !hit;

  // link engine: one machine so send and receive never overlap
  always_comb
  begin
    st_d = st_q;
    cnt_d = (cnt_q == 16'h0000) ? 16'h0000 : cnt_q - 16'h0001;
    bitn_d = bitn_q;
    shift_d = shift_q;
    rx_byte = 1'b0;
    restart_d = 1'b0;
    drive_low = 1'b0;
    ferr_d = 1'b0;
    coll_d = 1'b0;
    brk_d = 1'b0;
    err = 1'b0;
    case (st_q)
      dbg_link_pkg::LINK_IDLE:
      begin
        if (locked && line_low)
        begin
          st_d = dbg_link_pkg::LINK_RX_START;
          cnt_d = half_m1;
        end
        else if (locked && tx_pend_q)
        begin
          st_d = dbg_link_pkg::LINK_TX_START;
          cnt_d = per_m1;
          shift_d = tx_data_q;
        end
      end
      dbg_link_pkg::LINK_RX_START:
      begin
        if (cnt_q == 16'h0000)
        begin
          st_d = line_low ? dbg_link_pkg::LINK_RX_DATA
                          : dbg_link_pkg::LINK_IDLE;
          cnt_d = per_m1;
          bitn_d = 3'd0;
        end
      end
      dbg_link_pkg::LINK_RX_DATA:
      begin
        if (cnt_q == 16'h0000)
        begin
          shift_d = {!line_low, shift_q[7:1]};
          bitn_d = bitn_q + 3'd1;
          cnt_d = per_m1;
          if (bitn_q == dbg_link_pkg::LAST_DATA_BIT)
          begin
            st_d = dbg_link_pkg::LINK_RX_STOP;
          end
        end
      end
      dbg_link_pkg::LINK_RX_STOP:
      begin
        if (cnt_q == 16'h0000)
        begin
          if (line_low)
          begin
            ferr_d = 1'b1;
            err = 1'b1;
          end
          else
          begin
            rx_byte = 1'b1;
            st_d = dbg_link_pkg::LINK_IDLE;
          end
        end
      end
      dbg_link_pkg::LINK_TX_START, dbg_link_pkg::LINK_TX_DATA,
      dbg_link_pkg::LINK_TX_STOP:
      begin
        drive_low = st_q == dbg_link_pkg::LINK_TX_START ||
                    (st_q == dbg_link_pkg::LINK_TX_DATA && !shift_q[0]);
        if (!drive_low && line_low && cnt_q == half_m1)
        begin
          coll_d = 1'b1;
          err = 1'b1;
        end
        else if (cnt_q == 16'h0000)
        begin
          cnt_d = per_m1;
          if (st_q == dbg_link_pkg::LINK_TX_START)
          begin
            st_d = dbg_link_pkg::LINK_TX_DATA;
            bitn_d = 3'd0;
          end
          else if (st_q == dbg_link_pkg::LINK_TX_DATA)
          begin
            shift_d = {1'b1, shift_q[7:1]};
            bitn_d = bitn_q + 3'd1;
            if (bitn_q == dbg_link_pkg::LAST_DATA_BIT)
            begin
              st_d = dbg_link_pkg::LINK_TX_STOP;
            end
          end
          else
          begin
            st_d = dbg_link_pkg::LINK_IDLE;
          end
        end
      end
      dbg_link_pkg::LINK_BREAK:
      begin
        drive_low = 1'b1;
        if (cnt_q == 16'h0000)
        begin
          st_d = dbg_link_pkg::LINK_WAIT_HIGH;
        end
      end
      dbg_link_pkg::LINK_WAIT_HIGH:
      begin
        // held here until the host lets the line go
        if (!line_low)
        begin
          st_d = dbg_link_pkg::LINK_IDLE;
          restart_d = 1'b1;
        end
      end
      default:
      begin
        st_d = dbg_link_pkg::LINK_IDLE;
      end
    endcase
    if (line_break && st_q != dbg_link_pkg::LINK_BREAK &&
        st_q != dbg_link_pkg::LINK_WAIT_HIGH)
    begin
      brk_d = 1'b1;
      err = 1'b1;
    end
    if (err)
    begin
      // abort and answer with a four character break
      st_d = dbg_link_pkg::LINK_BREAK;
      cnt_d = dbg_link_pkg::bit_span(period,
                dbg_link_pkg::REPLY_BREAK_BITS) - 16'h0001;
      drive_low = 1'b0;
    end
    // re-detect the rate once the shared reset is released
    if (small_package_i && unlocked_q && shared_reset_pin_i && !shrst_q)
    begin
      restart_d = 1'b1;
    end
  end

  // register file and debug state
  always_comb
  begin
    rx_data_d = rx_byte ? shift_q : rx_data_q;
    rx_valid_d = rx_valid_q;
    if (rd && paddr == dbg_link_pkg::OFF_RXDATA)
    begin
      rx_valid_d = 1'b0;
    end
    if (rx_byte)
    begin
      rx_valid_d = 1'b1;
    end
    tx_data_d = tx_data_q;
    tx_pend_d = tx_pend_q;
    if (st_q == dbg_link_pkg::LINK_IDLE &&
        st_d == dbg_link_pkg::LINK_TX_START)
    begin
      tx_pend_d = 1'b0;
    end
    if (err)
    begin
      tx_pend_d = 1'b0;
    end
    else if (wr && paddr == dbg_link_pkg::OFF_TXDATA && !tx_pend_q)
    begin
      tx_data_d = pwdata[7:0];
      tx_pend_d = 1'b1;
    end
    key_d = key_q;
    unlocked_d = unlocked_q;
    if (rx_byte && small_package_i && !unlocked_q && !shared_reset_pin_i)
    begin
      key_d = {shift_q, key_q[31:8]};
      unlocked_d = key_d == dbg_link_pkg::UNLOCK_KEY;
    end
    bkpt_en_d = bkpt_en_q;
    debug_d = debug_q;
    inj_d = 1'b0;
    inj_op_d = inj_op_q;
    if (wr && paddr == dbg_link_pkg::OFF_CTRL)
    begin
      debug_d = pwdata[dbg_link_pkg::CTRL_DEBUG_BIT];
      bkpt_en_d = pwdata[dbg_link_pkg::CTRL_BKPT_EN_BIT];
    end
    if (wr && paddr == dbg_link_pkg::OFF_INJECT && debug_q)
    begin
      inj_d = 1'b1;
      inj_op_d = pwdata[7:0];
    end
    if (breakpoint_instruction_i && bkpt_en_q)
    begin
      debug_d = 1'b1;
    end
    if (sys_rst_q && !system_reset_i && pin_low_seen_q)
    begin
      debug_d = 1'b1;
    end
    if (system_reset_i)
    begin
      debug_d = 1'b0;
    end
    pin_low_seen_d = system_reset_i ? !debug_wire_pin_i : pin_low_seen_q;
    rdata_d = 32'h0000_0000;
    if (psel && !penable && !pwrite)
    begin
      case (paddr)
        dbg_link_pkg::OFF_CTRL:
        begin
          rdata_d[dbg_link_pkg::CTRL_DEBUG_BIT] = debug_q;
          rdata_d[dbg_link_pkg::CTRL_BKPT_EN_BIT] = bkpt_en_q;
        end
        dbg_link_pkg::OFF_STATUS:
        begin
          rdata_d[dbg_link_pkg::STAT_LOCKED_BIT] = locked;
          rdata_d[dbg_link_pkg::STAT_RX_VALID_BIT] = rx_valid_q;
          rdata_d[dbg_link_pkg::STAT_TX_BUSY_BIT] =
            tx_pend_q || st_q != dbg_link_pkg::LINK_IDLE;
          rdata_d[dbg_link_pkg::STAT_UNLOCKED_BIT] = unlocked_q;
          rdata_d[dbg_link_pkg::STAT_FRAME_ERR_BIT] = ferr_q;
          rdata_d[dbg_link_pkg::STAT_COLLISION_BIT] = coll_q;
          rdata_d[dbg_link_pkg::STAT_BREAK_BIT] = brk_q;
        end
        dbg_link_pkg::OFF_TXDATA:
        begin
          rdata_d[7:0] = tx_data_q;
        end
        dbg_link_pkg::OFF_RXDATA:
        begin
          rdata_d[7:0] = rx_data_q;
        end
        default:
        begin
          rdata_d = 32'h0000_0000;
        end
      endcase
    end
    else if (psel && penable)
    begin
      rdata_d = rdata_q;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      st_q <= dbg_link_pkg::LINK_IDLE;
      cnt_q <= 16'h0000;
      bitn_q <= 3'd0;
      shift_q <= 8'h00;
      rx_data_q <= 8'h00;
      rx_valid_q <= 1'b0;
      tx_data_q <= 8'h00;
      tx_pend_q <= 1'b0;
      ferr_q <= 1'b0;
      coll_q <= 1'b0;
      brk_q <= 1'b0;
      key_q <= 32'h0000_0000;
      unlocked_q <= 1'b0;
      shrst_q <= 1'b1;
      restart_q <= 1'b0;
      debug_q <= dbg_link_pkg::CTRL_DEBUG_RESET;
      bkpt_en_q <= dbg_link_pkg::CTRL_BKPT_EN_RESET;
      sys_rst_q <= 1'b0;
      pin_low_seen_q <= 1'b0;
      halt_exit_q <= 1'b0;
      wdt_q <= 1'b0;
      wake_q <= 1'b0;
      clk_run_q <= 1'b1;
      inj_q <= 1'b0;
      inj_op_q <= 8'h00;
      rdata_q <= 32'h0000_0000;
    end
    else
    begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      bitn_q <= bitn_d;
      shift_q <= shift_d;
      rx_data_q <= rx_data_d;
      rx_valid_q <= rx_valid_d;
      tx_data_q <= tx_data_d;
      tx_pend_q <= tx_pend_d;
      // sticky; a new event wins over the clearing write
      ferr_q <= ferr_d || (ferr_q && !(wr && paddr ==
                dbg_link_pkg::OFF_STATUS &&
                pwdata[dbg_link_pkg::STAT_FRAME_ERR_BIT]));
      coll_q <= coll_d || (coll_q && !(wr && paddr ==
                dbg_link_pkg::OFF_STATUS &&
                pwdata[dbg_link_pkg::STAT_COLLISION_BIT]));
      brk_q <= brk_d || (brk_q && !(wr && paddr ==
               dbg_link_pkg::OFF_STATUS &&
               pwdata[dbg_link_pkg::STAT_BREAK_BIT]));
      key_q <= key_d;
      unlocked_q <= unlocked_d;
      shrst_q <= shared_reset_pin_i;
      restart_q <= restart_d;
      debug_q <= debug_d;
      bkpt_en_q <= bkpt_en_d;
      sys_rst_q <= system_reset_i;
      pin_low_seen_q <= pin_low_seen_d;
      halt_exit_q <= debug_d && !debug_q;
      wdt_q <= debug_d && watchdog_enable_i;
      wake_q <= stop_mode_i && !debug_wire_pin_i;
      clk_run_q <= !stop_mode_i;
      inj_q <= inj_d;
      inj_op_q <= inj_op_d;
      rdata_q <= rdata_d;
    end
  end

  // pin only ever pulls low; the pull-up makes the high level
  assign debug_wire_pin_o = 1'b0;
  assign debug_wire_pin_oe_n = !drive_low;
  assign gpio_mode_o = small_package_i && !unlocked_q;
  assign prdata = rdata_q;
  assign fetch_stop_o = debug_q;
  assign halt_exit_o = halt_exit_q;
  assign clock_run_o = clk_run_q;
  assign watchdog_refresh_o = wdt_q;
  assign stop_wake_reset_o = wake_q;
  assign inject_valid_o = inj_q;
  assign inject_opcode_o = inj_op_q;
endmodule : single_wire_debug_link

// ==== logic/dbg_link_pkg.sv ====
package dbg_link_pkg;

  // register byte offsets on the bus
  localparam logic [7:0] OFF_CTRL = 8'h00;
  localparam logic [7:0] OFF_STATUS = 8'h04;
  localparam logic [7:0] OFF_TXDATA = 8'h08;
  localparam logic [7:0] OFF_RXDATA = 8'h0c;
  localparam logic [7:0] OFF_INJECT = 8'h10;

  // control fields
  localparam int CTRL_DEBUG_BIT = 0;
  localparam int CTRL_BKPT_EN_BIT = 1;
  localparam logic CTRL_DEBUG_RESET = 1'b0;
  localparam logic CTRL_BKPT_EN_RESET = 1'b0;

  // status fields
  localparam int STAT_LOCKED_BIT = 0;
  localparam int STAT_RX_VALID_BIT = 1;
  localparam int STAT_TX_BUSY_BIT = 2;
  localparam int STAT_UNLOCKED_BIT = 3;
  localparam int STAT_FRAME_ERR_BIT = 4;
  localparam int STAT_COLLISION_BIT = 5;
  localparam int STAT_BREAK_BIT = 6;

  // character and rate constants
  localparam int CNT_W = 16;
  localparam int PER_W = 10;
  localparam logic [5:0] AUTOBAUD_LOW_BITS = 6'd8;
  localparam logic [5:0] BREAK_BITS = 6'd9;
  localparam logic [5:0] REPLY_BREAK_BITS = 6'd40;
  localparam logic [2:0] LAST_DATA_BIT = 3'd7;
  localparam logic [15:0] MAX_BIT_CYCLES = 16'd512;
  localparam logic [15:0] MIN_BIT_CYCLES = 16'd4;
  localparam logic [31:0] UNLOCK_KEY = 32'hcd705aeb;

  typedef enum logic [3:0] {
    LINK_IDLE = 4'b0000,
    LINK_RX_START = 4'b0001,
    LINK_RX_DATA = 4'b0010,
    LINK_RX_STOP = 4'b0011,
    LINK_TX_START = 4'b0100,
    LINK_TX_DATA = 4'b0101,
    LINK_TX_STOP = 4'b0110,
    LINK_BREAK = 4'b0111,
    LINK_WAIT_HIGH = 4'b1000
  } link_state_e;

  // cycles covered by n bit periods
  function automatic logic [15:0] bit_span(logic [9:0] per, logic [5:0] n);
    bit_span = 16'({6'h00, per} * {10'h000, n});
  endfunction : bit_span

endpackage : dbg_link_pkg

// ==== logic/autobaud_meter.sv ====
`timescale 1ns/10ps
module autobaud_meter (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic restart,
  input wire logic line_low,
  output logic locked,
  output logic [9:0] bit_period,
  output logic line_break
);
  logic [15:0] run_q, run_d;
  logic locked_q, locked_d;
  logic [9:0] per_q, per_d;
  logic brk_q, brk_d;

  always_comb
  begin
    run_d = 16'h0000;
    if (line_low)
    begin
      run_d = (run_q == 16'hffff) ? run_q : run_q + 16'h0001;
    end
    locked_d = locked_q;
    per_d = per_q;
    brk_d = 1'b0;
    if (restart)
    begin
      locked_d = 1'b0;
    end
    else if (!locked_q && !line_low && run_q != 16'h0000)
    begin
      // low run of the first character spans eight bits
      if (run_q >= dbg_link_pkg::bit_span(10'(dbg_link_pkg::MIN_BIT_CYCLES),
                     dbg_link_pkg::AUTOBAUD_LOW_BITS) &&
          run_q <= dbg_link_pkg::bit_span(
                     10'(dbg_link_pkg::MAX_BIT_CYCLES),
                     dbg_link_pkg::AUTOBAUD_LOW_BITS))
      begin
        locked_d = 1'b1;
        per_d = run_q[12:3];
      end
    end
    else if (locked_q && line_low &&
             run_q == dbg_link_pkg::bit_span(per_q,
                                             dbg_link_pkg::BREAK_BITS))
    begin
      brk_d = 1'b1;
    end
  end

  always_ff @(posedge pclk or negedge presetn)
  begin
    if (!presetn)
    begin
      run_q <= 16'h0000;
      locked_q <= 1'b0;
      per_q <= 10'h000;
      brk_q <= 1'b0;
    end
    else
    begin
      run_q <= run_d;
      locked_q <= locked_d;
      per_q <= per_d;
      brk_q <= brk_d;
    end
  end

  assign locked = locked_q;
  assign bit_period = per_q;
  assign line_break = brk_q;
endmodule : autobaud_meter

// ==== bench/dbg_host_model.sv ====
`timescale 1ns/10ps
module dbg_host_model (
  input wire logic pclk,
  input wire logic pin_lvl,
  output logic pull_low
);
  // clock cycles per bit; the device measures it from the 80h character
  int per;
  initial
  begin
    per = 8;
    pull_low = 1'b0;
  end
  // only ever pulls low, so a device reply right after stop is never blocked
  task automatic hold_low(input int n);
    @(posedge pclk);
    pull_low <= 1'b1;
    repeat (n) @(posedge pclk);
    pull_low <= 1'b0;
  endtask : hold_low
  task automatic send_byte(input logic [7:0] b);
    logic [9:0] fr;
    fr = {1'b1, b, 1'b0};
    for (int i = 0; i < 10; i++)
    begin
      @(posedge pclk);
      pull_low <= !fr[i];
      repeat (per - 1) @(posedge pclk);
    end
    repeat (per) @(posedge pclk);
  endtask : send_byte
  // samples on the falling edge, away from the device's register updates
  task automatic recv_byte(output logic [7:0] b, output logic ok);
    int t;
    t = 0;
    b = 8'h00;
    ok = 1'b0;
    while (pin_lvl !== 1'b0 && t < 2000)
    begin
      @(negedge pclk);
      t++;
    end
    if (t < 2000)
    begin
      repeat (per / 2) @(negedge pclk);
      for (int i = 0; i < 8; i++)
      begin
        repeat (per) @(negedge pclk);
        b[i] = pin_lvl;
      end
      repeat (per) @(negedge pclk);
      ok = pin_lvl;
      // let the reply's stop bit end before the host may talk again
      repeat (per / 2) @(negedge pclk);
    end
  endtask : recv_byte
endmodule : dbg_host_model

// ==== bench/single_wire_debug_link_properties.sv ====
`timescale 1ns/10ps
module dbg_link_props (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [7:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  input wire logic debug_wire_pin_i,
  input wire logic debug_wire_pin_o,
  input wire logic small_package_i,
  input wire logic gpio_mode_o,
  input wire logic system_reset_i,
  input wire logic stop_mode_i,
  input wire logic stop_wake_reset_o,
  input wire logic breakpoint_instruction_i,
  input wire logic fetch_stop_o,
  input wire logic halt_exit_o,
  input wire logic clock_run_o,
  input wire logic watchdog_enable_i,
  input wire logic watchdog_refresh_o,
  input wire logic inject_valid_o,
  input wire logic [7:0] inject_opcode_o
);
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  logic wr_ctrl;
  logic wr_inj;
  logic [7:0] wbyte;
  assign wr_ctrl = psel && penable && pwrite
    && paddr == dbg_link_pkg::OFF_CTRL;
  assign wr_inj = psel && penable && pwrite
    && paddr == dbg_link_pkg::OFF_INJECT;
  assign wbyte = pwdata[7:0];
  pin_low_only_a: assert property (!debug_wire_pin_o)
    else $error("pin output not low");
  clock_run_a: assert property (
    $past(presetn) |-> clock_run_o == !$past(stop_mode_i))
    else $error("clock run wrong");
  halt_exit_a: assert property (
    $rose(fetch_stop_o) |-> ##[0:1] halt_exit_o)
    else $error("no halt exit pulse");
  halt_pulse_a: assert property (halt_exit_o |=> !halt_exit_o)
    else $error("halt exit too long");
  watchdog_on_a: assert property (
    (fetch_stop_o && watchdog_enable_i) [*2] |-> watchdog_refresh_o)
    else $error("no watchdog refresh");
  watchdog_off_a: assert property (
    !watchdog_enable_i [*2] |-> !watchdog_refresh_o)
    else $error("refresh while disabled");
  exit_write_a: assert property (
    wr_ctrl && !pwdata[dbg_link_pkg::CTRL_DEBUG_BIT]
    && !breakpoint_instruction_i |=> !fetch_stop_o)
    else $error("debug not left");
  sys_reset_a: assert property (system_reset_i |=> !fetch_stop_o)
    else $error("debug kept in reset");
  pin_entry_a: assert property (
    system_reset_i && !debug_wire_pin_i ##1 !system_reset_i
    |-> ##[1:2] fetch_stop_o)
    else $error("no entry by pin");
  stop_wake_a: assert property (
    stop_mode_i && !debug_wire_pin_i |=> stop_wake_reset_o)
    else $error("no wake reset");
  no_wake_a: assert property (!stop_mode_i |=> !stop_wake_reset_o)
    else $error("wake reset outside stop");
  inject_a: assert property (
    wr_inj && fetch_stop_o |=> inject_valid_o
    && inject_opcode_o == $past(wbyte))
    else $error("inject missing");
  no_inject_a: assert property (!fetch_stop_o |=> !inject_valid_o)
    else $error("inject outside debug");
  gpio_big_a: assert property (!small_package_i |-> !gpio_mode_o)
    else $error("gpio lock on big package");
  cover property ($rose(fetch_stop_o));
  cover property (stop_wake_reset_o);
  cover property (inject_valid_o);
endmodule : dbg_link_props
bind single_wire_debug_link dbg_link_props dbg_link_props_i (
  .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata,
  .debug_wire_pin_i, .debug_wire_pin_o, .small_package_i, .gpio_mode_o,
  .system_reset_i, .stop_mode_i, .stop_wake_reset_o,
  .breakpoint_instruction_i, .fetch_stop_o, .halt_exit_o, .clock_run_o,
  .watchdog_enable_i, .watchdog_refresh_o, .inject_valid_o,
  .inject_opcode_o
);

// ==== bench/testbench.sv ====
`timescale 1ns/10ps
module testbench;
  typedef struct packed
  {
    logic w;
    logic [7:0] a;
    logic [31:0] d;
    logic [31:0] r;
    logic e;
  } row_s;
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr;
  logic [7:0] paddr, inject_opcode_o, hb;
  logic [31:0] pwdata, prdata, rd;
  logic debug_wire_pin_i, debug_wire_pin_oe_n, pull_low, er, hok;
  logic small_package_i, shared_reset_pin_i, gpio_mode_o;
  logic system_reset_i, stop_mode_i, stop_wake_reset_o;
  logic breakpoint_instruction_i, fetch_stop_o, clock_run_o;
  logic watchdog_enable_i, watchdog_refresh_o;
  logic [7:0] key [0:4];
  row_s rows [0:4];
  int failures, n_tests;
  single_wire_debug_link single_wire_debug_link_i (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata,
    .pready, .pslverr, .debug_wire_pin_i, .debug_wire_pin_o(),
    .debug_wire_pin_oe_n, .small_package_i, .shared_reset_pin_i,
    .gpio_mode_o, .system_reset_i, .stop_mode_i, .stop_wake_reset_o,
    .breakpoint_instruction_i, .fetch_stop_o, .halt_exit_o(),
    .clock_run_o, .watchdog_enable_i, .watchdog_refresh_o,
    .inject_valid_o(), .inject_opcode_o
  );
  dbg_host_model dbg_host_model_i (
    .pclk, .pin_lvl(debug_wire_pin_i), .pull_low
  );
  // wired-and with pull-up: either party pulling low wins
  assign debug_wire_pin_i = !(pull_low || !debug_wire_pin_oe_n);
  initial
  begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  task automatic finish_test;
    $display("comparisons %0d mismatches %0d", n_tests, failures);
    if (failures == 0 && n_tests > 0)
      $display("TB: PASS");
    else
      $display("TB: FAIL");
    $finish;
  endtask : finish_test
  task automatic chk(input string nm, input logic [31:0] ex,
    input logic [31:0] got);
    n_tests++;
    if (got !== ex)
    begin
      $display("ERROR %s expected %h seen %h", nm, ex, got);
      failures++;
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask : tick
  // answer is taken at the edge that ends the access phase
  task automatic apb(input logic w, input logic [7:0] a,
    input logic [31:0] d);
    logic rdy;
    rdy = 1'b0;
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    for (int t = 0; t < 20 && rdy !== 1'b1; t++)
    begin
      @(posedge pclk);
      rd = prdata;
      er = pslverr;
      rdy = pready;
    end
    psel <= 1'b0;
    penable <= 1'b0;
    if (rdy !== 1'b1)
    begin
      failures++;
      finish_test();
    end
  endtask : apb
  task automatic bkpt;
    @(posedge pclk);
    breakpoint_instruction_i <= 1'b1;
    @(posedge pclk);
    breakpoint_instruction_i <= 1'b0;
    tick(1);
  endtask : bkpt
  task automatic status_locked(input logic ex);
    apb(1'b0, dbg_link_pkg::OFF_STATUS, 32'h0);
    chk("locked", ex, rd[dbg_link_pkg::STAT_LOCKED_BIT]);
  endtask : status_locked
  initial
  begin
    failures = 0;
    n_tests = 0;
    presetn = 1'b0;
    {psel, penable, pwrite, paddr, pwdata} = '0;
    {small_package_i, system_reset_i, stop_mode_i} = '0;
    breakpoint_instruction_i = 1'b0;
    shared_reset_pin_i = 1'b1;
    watchdog_enable_i = 1'b1;
    key = '{8'h80, 8'heb, 8'h5a, 8'h70, 8'hcd};
    rows[0] = '{1'b1, dbg_link_pkg::OFF_CTRL, 32'h2, 32'h0, 1'b0};
    rows[1] = '{1'b0, dbg_link_pkg::OFF_CTRL, 32'h0, 32'h2, 1'b0};
    rows[2] = '{1'b1, 8'hfc, 32'hffffffff, 32'h0, 1'b1};
    rows[3] = '{1'b0, 8'h14, 32'h0, 32'h0, 1'b1};
    rows[4] = '{1'b0, dbg_link_pkg::OFF_STATUS, 32'h0, 32'h0, 1'b0};
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    foreach (rows[i])
    begin
      apb(rows[i].w, rows[i].a, rows[i].d);
      if (!rows[i].w)
        chk("prdata", rows[i].r, rd);
      chk("pslverr", rows[i].e, er);
    end
    $display("register rows done");
    @(posedge pclk);
    presetn <= 1'b0;
    tick(2);
    chk("oe_n", 1'b1, debug_wire_pin_oe_n);
    chk("clock_run", 1'b1, clock_run_o);
    @(posedge pclk);
    presetn <= 1'b1;
    apb(1'b0, dbg_link_pkg::OFF_CTRL, 32'h0);
    chk("ctrl", 32'h0, rd);
    $display("reset test done");
    bkpt();
    chk("bkpt off", 1'b0, fetch_stop_o);
    apb(1'b1, dbg_link_pkg::OFF_CTRL, 32'h2);
    bkpt();
    chk("fetch_stop", 1'b1, fetch_stop_o);
    chk("wd_refresh", 1'b1, watchdog_refresh_o);
    @(posedge pclk);
    watchdog_enable_i <= 1'b0;
    tick(2);
    chk("wd_off", 1'b0, watchdog_refresh_o);
    @(posedge pclk);
    watchdog_enable_i <= 1'b1;
    apb(1'b1, dbg_link_pkg::OFF_INJECT, 32'h5c);
    tick(1);
    chk("opcode", 8'h5c, inject_opcode_o);
    apb(1'b1, dbg_link_pkg::OFF_CTRL, 32'h2);
    tick(1);
    chk("exit", 1'b0, fetch_stop_o);
    $display("breakpoint test done");
    fork
      dbg_host_model_i.hold_low(5200);
      begin
        tick(10);
        @(posedge pclk);
        system_reset_i <= 1'b1;
        tick(5);
        @(posedge pclk);
        system_reset_i <= 1'b0;
        tick(3);
        chk("pin entry", 1'b1, fetch_stop_o);
      end
    join
    @(posedge pclk);
    system_reset_i <= 1'b1;
    tick(2);
    chk("reset exit", 1'b0, fetch_stop_o);
    @(posedge pclk);
    system_reset_i <= 1'b0;
    $display("system reset test done");
    @(posedge pclk);
    stop_mode_i <= 1'b1;
    tick(2);
    chk("clock_run", 1'b0, clock_run_o);
    fork
      dbg_host_model_i.hold_low(6);
      begin
        tick(4);
        chk("stop wake", 1'b1, stop_wake_reset_o);
      end
    join
    @(posedge pclk);
    stop_mode_i <= 1'b0;
    tick(2);
    $display("stop test done");
    dbg_host_model_i.send_byte(8'h80);
    status_locked(1'b1);
    fork
      apb(1'b1, dbg_link_pkg::OFF_TXDATA, 32'ha5);
      dbg_host_model_i.recv_byte(hb, hok);
    join
    chk("tx byte", 8'ha5, hb);
    chk("tx stop", 1'b1, hok);
    dbg_host_model_i.send_byte(8'h3c);
    apb(1'b0, dbg_link_pkg::OFF_RXDATA, 32'h0);
    chk("rx byte", 32'h3c, rd);
    // reply lasts 40 periods from detection, which falls before release
    dbg_host_model_i.hold_low(10 * dbg_host_model_i.per);
    tick(36 * dbg_host_model_i.per);
    chk("break low", 1'b0, debug_wire_pin_oe_n);
    tick(8 * dbg_host_model_i.per);
    chk("break end", 1'b1, debug_wire_pin_oe_n);
    status_locked(1'b0);
    chk("break flag", 1'b1, rd[dbg_link_pkg::STAT_BREAK_BIT]);
    $display("link test done");
    @(posedge pclk);
    small_package_i <= 1'b1;
    shared_reset_pin_i <= 1'b0;
    tick(2);
    chk("gpio only", 1'b1, gpio_mode_o);
    foreach (key[i])
      dbg_host_model_i.send_byte(key[i]);
    tick(4);
    chk("pin freed", 1'b0, gpio_mode_o);
    @(posedge pclk);
    shared_reset_pin_i <= 1'b1;
    tick(2);
    status_locked(1'b0);
    dbg_host_model_i.send_byte(8'h80);
    status_locked(1'b1);
    $display("unlock test done");
    finish_test();
  end
endmodule : testbench
